// ===== rtl/wdr_pkg.sv
// package for the watchdog reload and service block
// Contract
// - reload count: byte, write-only, resets to 0Fh
// - watchdog idle until first reload-count write; a match error before it still raises the reset request
// - each later reload-count write restarts counter
// - writes cross from bus to watchdog domain
// - match byte 5Ch reloads counter when enabled
// - any other match byte raises watchdog error
// - two match writes per watchdog tick error
// - match writes ignored while servicing disabled
// - timer input is slow clock over six ratios
// - underflow rate is input over preset plus one
// - config bit picks input or underflow clock
// - no service within count resets the device
// - last-touch flag set while transfer pending
// - restart bit reloads timer, self-clears on edge
package wdr_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_PRESCALE = 8'h04;
    localparam logic [7:0] ADDR_TIMER_RELOAD = 8'h08;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_RELOAD_COUNT = 8'h10;
    localparam logic [7:0] ADDR_SERVICE_MATCH = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    // field positions in the config register
    localparam int CFG_CLK_SEL_BIT = 4;
    localparam int CFG_MATCH_EN_BIT = 5;
    // field positions in the timer control register
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_TC_BIT = 1;
    localparam int CTRL_LTD_BIT = 3;
    // interrupt status bits
    localparam int IRQ_EXPIRE_BIT = 0;
    localparam int IRQ_ERROR_BIT = 1;
    localparam int IRQ_TC_BIT = 2;
    // values after reset, the match key and the largest prescale code
    localparam logic [7:0] RELOAD_COUNT_RST = 8'h0F;
    localparam logic [15:0] TIMER_RELOAD_RST = 16'hFFFF;
    localparam logic [7:0] MATCH_KEY = 8'h5C;
    localparam logic [2:0] PRESCALE_MAX = 3'h5;
    // slow clock tick period in ref_clk cycles (32.768 kHz nominal)
    localparam int SLOW_DIV_RST = 305;
    // bus write request carried into the watchdog domain
    typedef struct packed {
        logic load;        // reload-count write pending
        logic service;     // good match service pending
        logic error;       // bad match write pending
    } wdr_req_type;
endpackage : wdr_pkg

// ===== rtl/wdr_top.sv
// watchdog reload, match service and timer clock chain with apb access
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module wdr_top #(
    parameter int SLOW_DIV = wdr_pkg::SLOW_DIV_RST
) (
    ref_clk,
    rst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    wd_reset_req,
    irq
);
    import wdr_pkg::*;
    // overview: software writes a reload count that starts the watchdog,
    // then keeps it alive by rewriting the count or by writing the match
    // key; a wrong key or a second key write in one watchdog tick is an
    // error that raises the same reset request as a counter expiry.
    // the slow side is not a real second clock here: it is a strobe
    // divided from ref_clk, so every register stays in one domain and
    // the crossing is modelled as a request held until the next tick.
    // trade-off: no synchroniser flops are needed, but the latency seen
    // by software is up to one full watchdog tick, never more.
    // the reset request output is a level that stays high until the
    // system reset clears it; the device reset logic outside decides
    // how long to act on it.
    // the interrupt output only mirrors the masked sticky status bits,
    // so software must read the status register to drop it.
    input wire logic ref_clk;
    input wire logic rst;
    input wire logic psel;
    input wire logic penable;
    input wire logic pwrite;
    input wire logic [7:0] paddr;
    input wire logic [31:0] pwdata;
    output logic [31:0] prdata;
    output logic pready;
    output logic pslverr;
    output logic wd_reset_req;
    output logic irq;

    // apb decode: zero-wait, answer in the access cycle itself
    // a write takes effect at the access edge; reads are latched at the
    // setup edge so prdata already stands when pready rises.
    // misaligned or out-of-range addresses never reach a register.
    logic wr_ok;
    logic rd_ok;
    logic mapped;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_IRQ_MASK);
    assign wr_ok = psel && penable && pwrite && mapped;
    assign rd_ok = psel && penable && !pwrite && mapped;

    // software registers
    logic [7:0] config_ff;          // timer_watchdog_config
    logic [2:0] prescale_ff;        // slow_clock_prescale
    logic [15:0] timer_reload_ff;   // timer_reload_value
    logic [7:0] reload_count_ff;    // watchdog_reload_count
    logic restart_ff;               // timer restart request
    logic tc_ff;                    // terminal count flag
    logic [2:0] irq_stat_ff;        // sticky event bits
    logic [2:0] irq_mask_ff;        // event enables
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic pready_ff;

    // slow clock tick and timer chain (watchdog domain strobes)
    logic [8:0] slow_cnt_ff;        // ref_clk cycles per slow tick
    logic slow_tick;
    logic [4:0] pre_cnt_ff;         // prescaler divider
    logic in_tick;                  // timer_input_clock edge
    logic [15:0] timer_cnt_ff;      // timer down counter
    logic out_tick;                 // timer_underflow_clock edge
    logic wd_tick;                  // selected watchdog clock edge

    // crossing: bus-side pending request and its watchdog-side take-up
    wdr_req_type pend_ff;           // requests waiting for a watchdog tick
    logic [7:0] wd_count_ff;        // watchdog down counter
    logic wd_run_ff;                // watchdog started
    logic svc_seen_ff;              // a match write landed in this tick
    logic expire;
    logic bad_write;
    logic good_write;
    logic [2:0] events;

    // slow clock reference: the block has a single clock, so the
    // slow clock is modelled as a tick divided from ref_clk
    // limitation: the divider restarts on every system reset, so the
    // phase of the first tick is fixed relative to reset release.
    // the counter is 9 bits wide, so SLOW_DIV may not exceed 512.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slow_cnt_ff <= 9'h000;
        end else if (slow_cnt_ff == 9'(SLOW_DIV - 1)) begin
            slow_cnt_ff <= 9'h000;
        end else begin
            slow_cnt_ff <= slow_cnt_ff + 9'h001;
        end
    end
    assign slow_tick = (slow_cnt_ff == 9'(SLOW_DIV - 1));

    // prescaler: divide slow tick by 1,2,4,8,16 or 32
    // the divider runs freely from reset, so a change of ratio takes
    // effect at the next roll-over of the selected bits.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_cnt_ff <= 5'h00;
        end else if (slow_tick) begin
            pre_cnt_ff <= pre_cnt_ff + 5'h01;
        end
    end
    // in_tick fires when the low prescale bits roll over
    assign in_tick = slow_tick &&
        ((pre_cnt_ff & 5'((6'h01 << prescale_ff) - 6'h01)) ==
        5'((6'h01 << prescale_ff) - 6'h01));

    // timer: reload on underflow or restart, counts input ticks
    // a pending restart reloads on the next input tick instead of
    // decrementing, and that tick is not reported as an underflow.
    // a preset of zero would underflow on every input tick.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timer_cnt_ff <= TIMER_RELOAD_RST;
        end else if (in_tick) begin
            if (restart_ff || timer_cnt_ff == 16'h0000) begin
                timer_cnt_ff <= timer_reload_ff;
            end else begin
                timer_cnt_ff <= timer_cnt_ff - 16'h0001;
            end
        end
    end
    // underflow period is preset+1 input ticks
    assign out_tick = in_tick && !restart_ff && (timer_cnt_ff == 16'h0000);
    assign wd_tick = config_ff[CFG_CLK_SEL_BIT] ? in_tick : out_tick;

    // config, prescale and timer reload registers
    // config bits 0 to 3 are stored for software but lock nothing here;
    // bits 6 and 7 are reserved and always read as zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            config_ff <= 8'h00;
            prescale_ff <= 3'h0;
            timer_reload_ff <= TIMER_RELOAD_RST;
            irq_mask_ff <= 3'h0;
        end else if (wr_ok) begin
            case (paddr)
                ADDR_CONFIG: begin
                    config_ff <= {2'h0, pwdata[5:0]};
                end
                ADDR_PRESCALE: begin
                    // reserved divisor codes are refused, keep the old one
                    if (pwdata[2:0] <= PRESCALE_MAX) begin
                        prescale_ff <= pwdata[2:0];
                    end
                end
                ADDR_TIMER_RELOAD: begin
                    timer_reload_ff <= pwdata[15:0];
                end
                ADDR_IRQ_MASK: begin
                    irq_mask_ff <= pwdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // restart bit: set by software, cleared on the input edge it acts on
    // writing zero to the restart bit has no effect; a write in the cycle
    // of an input tick wins and acts on the next tick, so it is never lost.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            restart_ff <= 1'b0;
        end else if (wr_ok && paddr == ADDR_TIMER_CTRL && pwdata[CTRL_RESTART_BIT]) begin
            restart_ff <= 1'b1;
        end else if (in_tick) begin
            restart_ff <= 1'b0;
        end
    end

    // reload count register lives on the bus side
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reload_count_ff <= RELOAD_COUNT_RST;
        end else if (wr_ok && paddr == ADDR_RELOAD_COUNT) begin
            reload_count_ff <= pwdata[7:0];
        end
    end

    // match write decode
    // a key write is good whenever matching is enabled and its byte is right,
    // even when another key write has landed since the last watchdog tick;
    // such a repeated key write is also flagged as bad, though its byte is right.
    // with matching disabled both strobes stay low: the write is lost.
    assign good_write = wr_ok && paddr == ADDR_SERVICE_MATCH &&
        config_ff[CFG_MATCH_EN_BIT] && pwdata[7:0] == MATCH_KEY;
    assign bad_write = wr_ok && paddr == ADDR_SERVICE_MATCH &&
        config_ff[CFG_MATCH_EN_BIT] &&
        (pwdata[7:0] != MATCH_KEY || svc_seen_ff);

    // pending requests: held until the next watchdog tick takes them, so
    // a service only lands on the slow side after a tick of latency
    // a new write in the same cycle as the tick wins and stays pending,
    // so no request is ever lost at the boundary.
    // software must keep the count large enough to cover this latency.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_ff <= '0;
        end else begin
            pend_ff.load <= (wr_ok && paddr == ADDR_RELOAD_COUNT) ||
                (pend_ff.load && !wd_tick);
            pend_ff.service <= good_write || (pend_ff.service && !wd_tick);
            pend_ff.error <= bad_write || (pend_ff.error && !wd_tick);
        end
    end

    // second match write before the tick is a double service
    // the set wins over the tick clear, so a key write at the tick edge
    // still guards the cycle that follows.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            svc_seen_ff <= 1'b0;
        end else if (good_write || bad_write) begin
            svc_seen_ff <= 1'b1;
        end else if (wd_tick) begin
            svc_seen_ff <= 1'b0;
        end
    end

    // watchdog counter: idle until first load, then counts watchdog ticks
    // a reload write beats a key service when both wait for one tick;
    // both load the same register, so the outcome is the same.
    // the counter parks at zero; expiry is decided separately below.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wd_run_ff <= 1'b0;
            wd_count_ff <= RELOAD_COUNT_RST;
        end else if (wd_tick) begin
            if (pend_ff.load) begin
                wd_run_ff <= 1'b1;
                wd_count_ff <= reload_count_ff;
            end else if (pend_ff.service && wd_run_ff) begin
                wd_count_ff <= reload_count_ff;
            end else if (wd_run_ff && wd_count_ff != 8'h00) begin
                wd_count_ff <= wd_count_ff - 8'h01;
            end
        end
    end
    // expiry: count already at zero with no service arriving
    // it fires once: while the reset request stands the parked counter
    // would otherwise report a fresh expiry on every tick and keep the
    // cleared status bit from ever staying clear.
    assign expire = wd_tick && wd_run_ff && wd_count_ff == 8'h00 && !wd_reset_req &&
        !pend_ff.load && !pend_ff.service;

    // device reset request: sticky until the system reset clears it
    // expiry and a service error are merged here, so software cannot
    // tell them apart from this pin; the status register keeps them apart.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wd_reset_req <= 1'b0;
        end else if (expire || (wd_tick && pend_ff.error)) begin
            wd_reset_req <= 1'b1;
        end
    end

    // terminal count flag, cleared by a read of timer control; set wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tc_ff <= 1'b0;
        end else if (out_tick) begin
            tc_ff <= 1'b1;
        end else if (rd_ok && paddr == ADDR_TIMER_CTRL) begin
            tc_ff <= 1'b0;
        end
    end

    // sticky interrupt status, cleared by read; a new event wins
    assign events = {out_tick, wd_tick && pend_ff.error, expire};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat_ff <= 3'h0;
        end else if (rd_ok && paddr == ADDR_IRQ_STATUS) begin
            irq_stat_ff <= events;
        end else begin
            irq_stat_ff <= irq_stat_ff | events;
        end
    end

    // interrupt level: registered so the pin comes from a flop, at the
    // cost of one cycle of lag behind the status and mask bits.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // read mux; write-only registers read as zero
    // the pending flag is read live so software can poll it before it
    // stops the clocks; the two write-only registers give no echo back.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_CONFIG: prdata_ff <= {24'h000000, config_ff};
                ADDR_PRESCALE: prdata_ff <= {29'h0, prescale_ff};
                ADDR_TIMER_RELOAD: prdata_ff <= {16'h0000, timer_reload_ff};
                ADDR_TIMER_CTRL: begin
                    prdata_ff <= {28'h0, pend_ff.load | pend_ff.service |
                        pend_ff.error, 1'b0, tc_ff, restart_ff};
                end
                ADDR_IRQ_STATUS: prdata_ff <= {29'h0, irq_stat_ff};
                ADDR_IRQ_MASK: prdata_ff <= {29'h0, irq_mask_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ready in the access cycle; unmapped or misaligned gives an error
    // every transfer takes exactly one access cycle, so a master that
    // waits for pready never stalls here.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && !penable;
            pslverr_ff <= psel && !penable && !mapped;
        end
    end
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

endmodule // wdr_top

// ===== test/wdr_properties.sv
// concurrent checks on the ports of the watchdog reload and service block
`timescale 1ns/10ps
module wdr_properties #(
    parameter int SLOW_DIV = 4
) (
    ref_clk,
    rst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    wd_reset_req,
    irq
);
    import wdr_pkg::*;
    input wire logic ref_clk, rst, psel, penable, pwrite; // clock, reset and apb controls
    input wire logic [7:0] paddr; // byte address
    input wire logic [31:0] pwdata, prdata; // bus data both ways
    input wire logic pready, pslverr, wd_reset_req, irq; // design answers
    logic arm_ff; // a write that may start the watchdog was accepted
    // remembers whether software has touched the reload or match register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arm_ff <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr[7:3] == 5'h02) begin
            arm_ff <= 1'b1; // 0x10 and 0x14 both count, the looser reading
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        psel && penable && pready;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> answer_s)
        else $error("no ready in the first access cycle");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    unmapped_err_a: assert property (psel && penable && pready
        && (paddr > ADDR_IRQ_MASK || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped address answered without error");
    wo_read_zero_a: assert property (pready && !pwrite && paddr[7:3] == 5'h02
        |-> prdata == 32'h0)
        else $error("write-only register read back nonzero");
    idle_until_start_a: assert property (!arm_ff |-> !wd_reset_req)
        else $error("reset request before the watchdog started");
    reset_sticky_a: assert property (wd_reset_req |=> $stable(wd_reset_req))
        else $error("reset request dropped");
endmodule // wdr_properties
bind wdr_top wdr_properties #(.SLOW_DIV(SLOW_DIV)) i_wdr_properties (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wd_reset_req(wd_reset_req), .irq(irq));

// ===== test/wdr_top_tb.sv
// self-checking bench for the watchdog reload and service block
`timescale 1ns/10ps
module wdr_top_tb;
    import wdr_pkg::*;
    localparam int DIV = 4; // short slow tick keeps the run brief; preset FFFF covers it
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wd_reset_req;
    logic irq;
    logic [31:0] rd; // data of the last transfer
    logic err; // error flag of the last transfer
    int miscompares = 0;
    int compares = 0;
    wdr_top #(.SLOW_DIV(DIV)) i_wdr_top (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wd_reset_req(wd_reset_req), .irq(irq));
    // free-running 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // one apb transfer; the wait for ready is bounded, not assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // reset again and start the watchdog with the given count and config
    task automatic start(input logic [31:0] cfg, input logic [7:0] cnt);
        rst <= 1'b1;
        wt(5);
        rst <= 1'b0;
        apb(1'b1, ADDR_CONFIG, cfg);
        apb(1'b1, ADDR_RELOAD_COUNT, {24'h0, cnt});
        apb(1'b1, ADDR_TIMER_CTRL, 32'h1);
    endtask
    task automatic close_out();
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // cuts a hang short; the tests need well under a millisecond
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end
    initial begin
        wt(5);
        rst <= 1'b0;
        apb(1'b0, ADDR_TIMER_RELOAD, 32'h0);
        chk(rd, {16'h0, TIMER_RELOAD_RST});
        apb(1'b0, ADDR_RELOAD_COUNT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h22, 32'hFF);
        chk({31'h0, err}, 32'h1);
        wt(100);
        chk({31'h0, wd_reset_req}, 32'h0);
        // short preset and a restart: underflow flag, restart self-clears
        apb(1'b1, ADDR_TIMER_RELOAD, 32'h1);
        apb(1'b1, ADDR_TIMER_CTRL, 32'h1);
        wt(20);
        apb(1'b0, ADDR_TIMER_CTRL, 32'h0);
        chk({30'h0, rd[CTRL_TC_BIT], rd[CTRL_RESTART_BIT]}, 32'h2);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk({31'h0, rd[IRQ_TC_BIT]}, 32'h1);
        // expiry with the interrupt unmasked
        start(32'h10, 8'h03);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        chk({31'h0, wd_reset_req}, 32'h0);
        wt(40);
        chk({30'h0, irq, wd_reset_req}, 32'h3);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk({31'h0, rd[IRQ_EXPIRE_BIT]}, 32'h1);
        wt(3);
        chk({31'h0, irq}, 32'h0);
        // rewriting the count keeps the watchdog alive
        start(32'h10, 8'h0A);
        repeat (6) begin
            wt(20);
            apb(1'b1, ADDR_RELOAD_COUNT, 32'h0A);
        end
        chk({31'h0, wd_reset_req}, 32'h0);
        wt(80);
        chk({31'h0, wd_reset_req}, 32'h1);
        // match byte services; disabled matching ignores writes
        start(32'h3F, 8'h0A);
        repeat (6) begin
            wt(20);
            apb(1'b1, ADDR_SERVICE_MATCH, {24'h0, MATCH_KEY});
        end
        chk({31'h0, wd_reset_req}, 32'h0);
        apb(1'b1, ADDR_CONFIG, 32'h10);
        apb(1'b1, ADDR_SERVICE_MATCH, 32'h5B);
        wt(8);
        chk({31'h0, wd_reset_req}, 32'h0);
        wt(80);
        chk({31'h0, wd_reset_req}, 32'h1);
        // wrong byte is an error; masked interrupt stays low
        start(32'h30, 8'h0A);
        wt(10);
        apb(1'b1, ADDR_SERVICE_MATCH, 32'h5B);
        wt(12);
        chk({30'h0, irq, wd_reset_req}, 32'h1);
        // slowest prescale: pending flag and double service
        start(32'h30, 8'h0A);
        apb(1'b1, ADDR_PRESCALE, 32'h5);
        apb(1'b1, ADDR_RELOAD_COUNT, 32'h0A);
        apb(1'b0, ADDR_TIMER_CTRL, 32'h0);
        chk({31'h0, rd[CTRL_LTD_BIT]}, 32'h1);
        wt(300);
        apb(1'b0, ADDR_TIMER_CTRL, 32'h0);
        chk({31'h0, rd[CTRL_LTD_BIT]}, 32'h0);
        apb(1'b1, ADDR_SERVICE_MATCH, {24'h0, MATCH_KEY});
        apb(1'b1, ADDR_SERVICE_MATCH, {24'h0, MATCH_KEY});
        chk({31'h0, wd_reset_req}, 32'h0);
        wt(300);
        chk({31'h0, wd_reset_req}, 32'h1);
        close_out();
    end
endmodule // wdr_top_tb
